/* File: logic/eli_line_ctrl.v */
`timescale 1ns/1ps
`include "eli_defs.vh"
module eli_line_ctrl #(
  parameter TCLK_LOSS_CYC = `ELI_TCLK_LOSS_CYC
) (
  input  wire       clk_sys_i,
  input  wire       resetn_i,
  input  wire       sw_reset_i,
  input  wire       reg_cs_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire [5:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  output wire [7:0] reg_rdata_o,
  input  wire       hw_mode_pin_i,
  input  wire       tx_force_hiz_pin_i,
  input  wire       hw_impedance_sel_pin_i,
  input  wire       hw_bridge_gain_pin_i,
  input  wire [1:0] hw_tx_sequence_pins_i,
  input  wire [1:0] hw_path_coding_pins_i,
  input  wire [3:0] hw_wave_template_pins_i,
  input  wire       mclk_pin_i,
  input  wire       tx_line_clock_i,
  input  wire       remote_loopback_i,
  input  wire       tx_pattern_mclk_i,
  input  wire [1:0] shaper_ui_i,
  input  wire [3:0] shaper_phase_i,
  input  wire       slicer_pos_i,
  input  wire       slicer_neg_i,
  input  wire       cdr_pos_i,
  input  wire       cdr_neg_i,
  input  wire       cdr_clk_i,
  output wire       tx_line_oe_o,
  output wire       tx_power_down_o,
  output wire [2:0] tx_term_code_o,
  output wire [2:0] rx_term_code_o,
  output wire [6:0] wave_sample_value_o,
  output wire [7:0] amplitude_pct_o,
  output wire [1:0] monitor_gain_field_o,
  output wire       adaptive_gain_enable_o,
  output wire       rx_sens_high_o,
  output wire [4:0] los_level_o,
  output wire [1:0] decision_level_sel_o,
  output wire [1:0] rx_coding_cfg_o,
  output wire       clock_data_recovery_bypass_o,
  output wire       rx_data_pos_out_o,
  output wire       rx_data_neg_out_o,
  output wire       rx_recovered_clock_o
);
  reg [7:0] line_imp_reg;
  reg [7:0] tx_cfg0_reg;
  reg [7:0] tx_cfg1_reg;
  reg [5:0] gain_step_reg;
  reg [5:0] wave_addr_reg;
  reg [6:0] wave_data_reg;
  reg [7:0] rx_cfg0_reg;
  reg [7:0] rx_cfg1_reg;
  reg [7:0] rx_cfg2_reg;
  reg [7:0] rdata_reg;
  reg [6:0] wave_ram [0:63];

  // straps and the force pin are asynchronous pins: two flops first
  reg [11:0] pin_meta_reg;
  reg [11:0] pin_sync_reg;

  reg       oe_reg;
  reg       pdn_reg;
  reg [2:0] tx_term_reg;
  reg [2:0] rx_term_reg;
  reg [6:0] sample_reg;
  reg [7:0] pct_reg;
  reg [1:0] mg_reg;
  reg       eq_reg;
  reg       sens_reg;
  reg [4:0] los_reg;
  reg [1:0] decision_level_sel_reg;
  reg [1:0] coding_reg;
  reg       bypass_reg;
  reg       rdp_reg;
  reg       rdn_reg;
  reg       rclk_reg;

  wire       mclk_lost;
  wire       tclk_lost;
  wire       hw_mode;
  wire       force_pin;
  wire       imp_pin;
  wire       bridge_pin;
  wire [1:0] seq_pins;
  wire [1:0] coding_pins;
  wire [3:0] tmpl_pins;
  wire       wr_en;
  wire       rd_en;
  wire [3:0] tmpl_sel;
  wire       user_wave;
  wire [2:0] tx_term_next;
  wire [2:0] rx_term_next;
  wire       pdn_next;
  wire       hiz_next;
  wire [1:0] coding_next;
  wire       bypass_next;

  eli_clk_watch #(
    .LIMIT (`ELI_MCLK_LOSS_CYC)
  ) u_mclk_watch (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .pin_clk_i (mclk_pin_i),
    .lost_o    (mclk_lost)
  );

  eli_clk_watch #(
    .LIMIT (TCLK_LOSS_CYC)
  ) u_tclk_watch (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .pin_clk_i (tx_line_clock_i),
    .lost_o    (tclk_lost)
  );

  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      pin_meta_reg <= 12'h000;
      pin_sync_reg <= 12'h000;
    end else begin
      pin_meta_reg <= {hw_mode_pin_i, tx_force_hiz_pin_i, hw_impedance_sel_pin_i,
                       hw_bridge_gain_pin_i, hw_tx_sequence_pins_i,
                       hw_path_coding_pins_i, hw_wave_template_pins_i};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign hw_mode     = pin_sync_reg[11];
  assign force_pin   = pin_sync_reg[10];
  assign imp_pin     = pin_sync_reg[9];
  assign bridge_pin  = pin_sync_reg[8];
  assign seq_pins    = pin_sync_reg[7:6];
  assign coding_pins = pin_sync_reg[5:4];
  assign tmpl_pins   = pin_sync_reg[3:0];

  assign wr_en = reg_cs_i & reg_wr_i;
  assign rd_en = reg_cs_i & reg_rd_i & ~reg_wr_i;

  // 75 ohm and 120 ohm preset tables, phase n is sample n
  function [6:0] preset_sample;
    input       is_120;
    input [1:0] ui;
    input [3:0] ph;
    begin
      preset_sample = `ELI_W_ZERO;
      if (ui == 2'b00) begin
        if (ph == `ELI_EDGE_PHASE) begin
          preset_sample = is_120 ? `ELI_W120_EDGE : `ELI_W75_EDGE;
        end else if (ph >= `ELI_BODY_FIRST && ph <= `ELI_BODY_LAST) begin
          preset_sample = is_120 ? `ELI_W120_BODY : `ELI_W75_BODY;
        end
      end
    end
  endfunction

  // register writes and the waveform ram access
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      line_imp_reg  <= `ELI_RST_LINE_IMP;
      tx_cfg0_reg   <= `ELI_RST_TX_CFG0;
      tx_cfg1_reg   <= `ELI_RST_TX_CFG1;
      gain_step_reg <= `ELI_RST_GAIN_STEP;
      wave_addr_reg <= 6'h00;
      wave_data_reg <= 7'h00;
      rx_cfg0_reg   <= `ELI_RST_RX_CFG0;
      rx_cfg1_reg   <= `ELI_RST_RX_CFG1;
      rx_cfg2_reg   <= `ELI_RST_RX_CFG2;
    end else if (wr_en) begin
      if (reg_addr_i == `ELI_OFS_LINE_IMP) begin
        line_imp_reg <= reg_wdata_i;
      end else if (reg_addr_i == `ELI_OFS_TX_CFG0) begin
        tx_cfg0_reg <= reg_wdata_i;
      end else if (reg_addr_i == `ELI_OFS_TX_CFG1) begin
        tx_cfg1_reg <= reg_wdata_i;
      end else if (reg_addr_i == `ELI_OFS_TX_CFG2) begin
        gain_step_reg <= reg_wdata_i[5:0];
      end else if (reg_addr_i == `ELI_OFS_WAVE_CTRL) begin
        wave_addr_reg <= reg_wdata_i[5:0];
        if (reg_wdata_i[`ELI_WAVE_DONE_BIT] && reg_wdata_i[`ELI_WAVE_RD_BIT]) begin
          wave_data_reg <= wave_ram[reg_wdata_i[5:0]];
        end
      end else if (reg_addr_i == `ELI_OFS_WAVE_DATA) begin
        wave_data_reg <= reg_wdata_i[6:0];
      end else if (reg_addr_i == `ELI_OFS_RX_CFG0) begin
        rx_cfg0_reg <= reg_wdata_i;
      end else if (reg_addr_i == `ELI_OFS_RX_CFG1) begin
        rx_cfg1_reg <= reg_wdata_i;
      end else if (reg_addr_i == `ELI_OFS_RX_CFG2) begin
        rx_cfg2_reg <= reg_wdata_i;
      end
    end
  end

  // ram has no reset: user templates must be written before use
  always @(posedge clk_sys_i) begin
    if (wr_en && reg_addr_i == `ELI_OFS_WAVE_CTRL && reg_wdata_i[`ELI_WAVE_DONE_BIT] &&
        !reg_wdata_i[`ELI_WAVE_RD_BIT]) begin
      wave_ram[reg_wdata_i[5:0]] <= wave_data_reg;
    end
  end

  // read data; unmapped offsets answer zero, done bit reads back zero
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rdata_reg <= 8'h00;
    end else if (rd_en) begin
      if (reg_addr_i == `ELI_OFS_LINE_IMP) begin
        rdata_reg <= line_imp_reg;
      end else if (reg_addr_i == `ELI_OFS_TX_CFG0) begin
        rdata_reg <= tx_cfg0_reg;
      end else if (reg_addr_i == `ELI_OFS_TX_CFG1) begin
        rdata_reg <= tx_cfg1_reg;
      end else if (reg_addr_i == `ELI_OFS_TX_CFG2) begin
        rdata_reg <= {2'b00, gain_step_reg};
      end else if (reg_addr_i == `ELI_OFS_WAVE_CTRL) begin
        rdata_reg <= {2'b00, wave_addr_reg};
      end else if (reg_addr_i == `ELI_OFS_WAVE_DATA) begin
        rdata_reg <= {1'b0, wave_data_reg};
      end else if (reg_addr_i == `ELI_OFS_RX_CFG0) begin
        rdata_reg <= rx_cfg0_reg;
      end else if (reg_addr_i == `ELI_OFS_RX_CFG1) begin
        rdata_reg <= rx_cfg1_reg;
      end else if (reg_addr_i == `ELI_OFS_RX_CFG2) begin
        rdata_reg <= rx_cfg2_reg;
      end else begin
        rdata_reg <= 8'h00;
      end
    end
  end

  // strap selection
  assign tmpl_sel  = hw_mode ? tmpl_pins : tx_cfg1_reg[3:0];
  assign user_wave = (tmpl_sel[3:2] == 2'b11);

  // internal impedance comes from the template pins in hw mode
  assign tx_term_next = hw_mode ? (imp_pin ? `ELI_TERM_EXT :
                                   (tmpl_pins == 4'h0 ? `ELI_TERM_75 : `ELI_TERM_120))
                      : (line_imp_reg[`ELI_T_TERM_LSB+2] ? `ELI_TERM_EXT
                         : {1'b0, line_imp_reg[`ELI_T_TERM_LSB+1:`ELI_T_TERM_LSB]});
  assign rx_term_next = hw_mode ? tx_term_next
                      : (line_imp_reg[`ELI_R_TERM_LSB+2] ? `ELI_TERM_EXT
                         : {1'b0, line_imp_reg[`ELI_R_TERM_LSB+1:`ELI_R_TERM_LSB]});

  assign pdn_next = hw_mode ? (seq_pins == `ELI_TX_SEQ_OFF)
                            : tx_cfg0_reg[`ELI_TX_OFF_BIT];

  // tx circuits keep running while forced; only the driver enable drops
  assign hiz_next = force_pin | (~hw_mode & tx_cfg1_reg[`ELI_TX_HIZ_BIT])
                  | mclk_lost | pdn_next | sw_reset_i
                  | (tclk_lost & ~remote_loopback_i & ~tx_pattern_mclk_i);

  assign coding_next = hw_mode ? coding_pins : rx_cfg0_reg[1:0];
  assign bypass_next = (coding_next == `ELI_CODING_SLICER);

  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      oe_reg      <= 1'b0;
      pdn_reg     <= 1'b0;
      tx_term_reg <= `ELI_TERM_75;
      rx_term_reg <= `ELI_TERM_75;
      sample_reg  <= 7'h00;
      pct_reg     <= `ELI_PCT_NOMINAL;
      mg_reg      <= `ELI_MG_0DB;
      eq_reg      <= 1'b0;
      sens_reg    <= 1'b0;
      los_reg     <= 5'h00;
      decision_level_sel_reg   <= 2'b00;
      coding_reg  <= 2'b00;
      bypass_reg  <= 1'b0;
      rdp_reg     <= 1'b0;
      rdn_reg     <= 1'b0;
      rclk_reg    <= 1'b0;
    end else begin
      oe_reg      <= ~hiz_next;
      pdn_reg     <= pdn_next;
      tx_term_reg <= tx_term_next;
      rx_term_reg <= rx_term_next;
      if (user_wave) begin
        sample_reg <= wave_ram[{shaper_ui_i, shaper_phase_i}];
        pct_reg    <= gain_step_reg * `ELI_PCT_STEP + `ELI_PCT_BASE;
      end else begin
        // presets are never scaled
        sample_reg <= preset_sample(tmpl_sel != 4'h0, shaper_ui_i, shaper_phase_i);
        pct_reg    <= `ELI_PCT_NOMINAL;
      end
      mg_reg <= hw_mode ? (bridge_pin ? `ELI_MG_26DB : `ELI_MG_0DB)
                        : rx_cfg2_reg[`ELI_MG_LSB+1:`ELI_MG_LSB];
      eq_reg     <= ~hw_mode & rx_cfg1_reg[`ELI_ADAPTIVE_GAIN_ENABLE_BIT];
      sens_reg   <= ~hw_mode & rx_cfg1_reg[`ELI_ADAPTIVE_GAIN_ENABLE_BIT];
      los_reg    <= hw_mode ? 5'h00 : rx_cfg1_reg[4:0];
      decision_level_sel_reg  <= rx_cfg2_reg[1:0];
      coding_reg <= coding_next;
      bypass_reg <= bypass_next;
      if (bypass_next) begin
        rdp_reg  <= slicer_pos_i;
        rdn_reg  <= slicer_neg_i;
        rclk_reg <= slicer_pos_i ^ slicer_neg_i;
      end else begin
        rdp_reg  <= cdr_pos_i;
        rdn_reg  <= cdr_neg_i;
        rclk_reg <= cdr_clk_i;
      end
    end
  end

  assign reg_rdata_o                  = rdata_reg;
  assign tx_line_oe_o                 = oe_reg;
  assign tx_power_down_o              = pdn_reg;
  assign tx_term_code_o               = tx_term_reg;
  assign rx_term_code_o               = rx_term_reg;
  assign wave_sample_value_o          = sample_reg;
  assign amplitude_pct_o              = pct_reg;
  assign monitor_gain_field_o         = mg_reg;
  assign adaptive_gain_enable_o       = eq_reg;
  assign rx_sens_high_o               = sens_reg;
  assign los_level_o                  = los_reg;
  assign decision_level_sel_o         = decision_level_sel_reg;
  assign rx_coding_cfg_o              = coding_reg;
  assign clock_data_recovery_bypass_o = bypass_reg;
  assign rx_data_pos_out_o            = rdp_reg;
  assign rx_data_neg_out_o            = rdn_reg;
  assign rx_recovered_clock_o         = rclk_reg;
endmodule

/* File: logic/eli_defs.vh */
`ifndef ELI_DEFS_VH
`define ELI_DEFS_VH

// register offsets
`define ELI_OFS_LINE_IMP   6'h02
`define ELI_OFS_TX_CFG0    6'h04
`define ELI_OFS_TX_CFG1    6'h05
`define ELI_OFS_TX_CFG2    6'h06
`define ELI_OFS_WAVE_CTRL  6'h07
`define ELI_OFS_WAVE_DATA  6'h08
`define ELI_OFS_RX_CFG0    6'h09
`define ELI_OFS_RX_CFG1    6'h0a
`define ELI_OFS_RX_CFG2    6'h0b

// reset values
`define ELI_RST_LINE_IMP   8'h00
`define ELI_RST_TX_CFG0    8'h00
`define ELI_RST_TX_CFG1    8'h00
`define ELI_RST_GAIN_STEP  6'h21
`define ELI_RST_RX_CFG0    8'h00
`define ELI_RST_RX_CFG1    8'h00
`define ELI_RST_RX_CFG2    8'h00

// field positions
`define ELI_TERM_EXT_BIT   2
`define ELI_T_TERM_LSB     0
`define ELI_R_TERM_LSB     3
`define ELI_TX_OFF_BIT     4
`define ELI_TX_HIZ_BIT     4
`define ELI_WAVE_DONE_BIT  7
`define ELI_WAVE_RD_BIT    6
`define ELI_ADAPTIVE_GAIN_ENABLE_BIT      7
`define ELI_MG_LSB         2

// impedance codes
`define ELI_TERM_75        3'b000
`define ELI_TERM_120       3'b001
`define ELI_TERM_EXT       3'b100

// preset waveform samples
`define ELI_W75_EDGE       7'h0c
`define ELI_W75_BODY       7'h30
`define ELI_W120_EDGE      7'h0f
`define ELI_W120_BODY      7'h3c
`define ELI_W_ZERO         7'h00
`define ELI_EDGE_PHASE     4'h3
`define ELI_BODY_FIRST     4'h4
`define ELI_BODY_LAST      4'hb

// monitor gain codes
`define ELI_MG_0DB         2'b00
`define ELI_MG_26DB        2'b10

// coding mode that bypasses clock recovery, and the tx sequence code that powers down
`define ELI_CODING_SLICER  2'b11
`define ELI_TX_SEQ_OFF     2'b11

// amplitude: percent = step * 3 + 1 (step 33 gives 100)
`define ELI_PCT_STEP       8'd3
`define ELI_PCT_BASE       8'd1
`define ELI_PCT_NOMINAL    8'd100

// clock loss timing
`define ELI_CLK_MHZ        125
`define ELI_MCLK_LOSS_NS   1000
`define ELI_TCLK_LOSS_NS   34180
`define ELI_MCLK_LOSS_CYC  ((`ELI_MCLK_LOSS_NS * `ELI_CLK_MHZ) / 1000)
`define ELI_TCLK_LOSS_CYC  ((`ELI_TCLK_LOSS_NS * `ELI_CLK_MHZ) / 1000)

`endif

/* File: logic/eli_clk_watch.v */
`timescale 1ns/1ps
// synchronises a pin clock and flags it lost after LIMIT cycles with no edge
module eli_clk_watch #(
  parameter LIMIT = 125
) (
  input  wire clk_sys_i,
  input  wire resetn_i,
  input  wire pin_clk_i,
  output wire lost_o
);
  reg        meta_reg;
  reg        sync_reg;
  reg        prev_reg;
  reg [15:0] cnt_reg;
  reg        lost_reg;

  // lost from reset until the first edge, so outputs start safe
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
      prev_reg <= 1'b0;
      cnt_reg  <= 16'h0000;
      lost_reg <= 1'b1;
    end else begin
      meta_reg <= pin_clk_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
      if (sync_reg != prev_reg) begin
        cnt_reg  <= 16'h0000;
        lost_reg <= 1'b0;
      end else if (cnt_reg >= LIMIT[15:0]) begin
        lost_reg <= 1'b1;
      end else begin
        cnt_reg <= cnt_reg + 16'h0001;
      end
    end
  end

  assign lost_o = lost_reg;
endmodule

/* File: verification/eli_line_ctrl_properties.sv */
`timescale 1ns/1ps
module eli_line_ctrl_checker #(
  parameter TCLK_LOSS_CYC = 4272
) (
  input wire       clk_sys_i,
  input wire       resetn_i,
  input wire       sw_reset_i,
  input wire       hw_mode_pin_i,
  input wire       tx_force_hiz_pin_i,
  input wire       hw_impedance_sel_pin_i,
  input wire       hw_bridge_gain_pin_i,
  input wire [1:0] hw_tx_sequence_pins_i,
  input wire       slicer_pos_i,
  input wire       slicer_neg_i,
  input wire       cdr_pos_i,
  input wire       cdr_clk_i,
  input wire       tx_line_oe_o,
  input wire       tx_power_down_o,
  input wire [2:0] tx_term_code_o,
  input wire [2:0] rx_term_code_o,
  input wire [1:0] monitor_gain_field_o,
  input wire       adaptive_gain_enable_o,
  input wire       rx_sens_high_o,
  input wire [1:0] rx_coding_cfg_o,
  input wire       clock_data_recovery_bypass_o,
  input wire       rx_data_pos_out_o,
  input wire       rx_data_neg_out_o,
  input wire       rx_recovered_clock_o
);
  reg  [2:0] up_cnt_reg;
  wire       up_ok;
  // pin synchronisers and output flops need a few edges after reset to flush
  always @(posedge clk_sys_i) begin
    if (!resetn_i) up_cnt_reg <= 3'h0;
    else if (up_cnt_reg != 3'h7) up_cnt_reg <= up_cnt_reg + 3'h1;
  end
  assign up_ok = (up_cnt_reg >= 3'h3);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence byp_held;
    up_ok && clock_data_recovery_bypass_o ##1 clock_data_recovery_bypass_o;
  endsequence
  sequence cdr_held;
    up_ok && !clock_data_recovery_bypass_o ##1 !clock_data_recovery_bypass_o;
  endsequence
  force_hiz_a: assert property (tx_force_hiz_pin_i [*4] |-> !tx_line_oe_o)
    else $error("tx line driven while force pin high");
  sw_reset_hiz_a: assert property (sw_reset_i [*3] |-> !tx_line_oe_o)
    else $error("tx line driven during software reset");
  pdn_hiz_a: assert property (tx_power_down_o [*2] |-> !tx_line_oe_o)
    else $error("tx line driven while powered down");
  hw_pdn_a: assert property ((up_ok && hw_mode_pin_i && hw_tx_sequence_pins_i == 2'h3) [*4]
    |-> tx_power_down_o) else $error("sequence pins 11 did not power down");
  hw_bridge_a: assert property ((up_ok && hw_mode_pin_i && $stable(hw_bridge_gain_pin_i)) [*4]
    |-> monitor_gain_field_o == (hw_bridge_gain_pin_i ? 2'h2 : 2'h0))
    else $error("monitor gain does not follow bridge pin");
  hw_ext_term_a: assert property ((up_ok && hw_mode_pin_i && hw_impedance_sel_pin_i) [*4]
    |-> tx_term_code_o == 3'h4 && rx_term_code_o == 3'h4)
    else $error("impedance pin high did not pick external termination");
  hw_eq_off_a: assert property ((up_ok && hw_mode_pin_i) [*4]
    |-> !adaptive_gain_enable_o && !rx_sens_high_o) else $error("equalizer on in pin mode");
  sens_follow_a: assert property ((up_ok && $stable(adaptive_gain_enable_o)) [*2]
    |-> rx_sens_high_o == adaptive_gain_enable_o) else $error("sensitivity mismatch");
  bypass_code_a: assert property ((up_ok && $stable(rx_coding_cfg_o)) [*2]
    |-> clock_data_recovery_bypass_o == (rx_coding_cfg_o == 2'h3))
    else $error("bypass flag does not match coding");
  slicer_rails_a: assert property (byp_held |-> rx_data_pos_out_o == $past(slicer_pos_i)
    && rx_data_neg_out_o == $past(slicer_neg_i)) else $error("rails not from slicer");
  rclk_xor_a: assert property (byp_held
    |-> rx_recovered_clock_o == (rx_data_pos_out_o ^ rx_data_neg_out_o))
    else $error("recovered clock is not rail xor");
  cdr_pass_a: assert property (cdr_held |-> rx_data_pos_out_o == $past(cdr_pos_i)
    && rx_recovered_clock_o == $past(cdr_clk_i)) else $error("rails not from recovery");
endmodule
bind eli_line_ctrl eli_line_ctrl_checker #(.TCLK_LOSS_CYC(TCLK_LOSS_CYC)) u_chk (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .sw_reset_i(sw_reset_i),
  .hw_mode_pin_i(hw_mode_pin_i), .tx_force_hiz_pin_i(tx_force_hiz_pin_i),
  .hw_impedance_sel_pin_i(hw_impedance_sel_pin_i), .hw_bridge_gain_pin_i(hw_bridge_gain_pin_i),
  .hw_tx_sequence_pins_i(hw_tx_sequence_pins_i), .slicer_pos_i(slicer_pos_i),
  .slicer_neg_i(slicer_neg_i), .cdr_pos_i(cdr_pos_i), .cdr_clk_i(cdr_clk_i),
  .tx_line_oe_o(tx_line_oe_o), .tx_power_down_o(tx_power_down_o),
  .tx_term_code_o(tx_term_code_o), .rx_term_code_o(rx_term_code_o),
  .monitor_gain_field_o(monitor_gain_field_o), .adaptive_gain_enable_o(adaptive_gain_enable_o),
  .rx_sens_high_o(rx_sens_high_o), .rx_coding_cfg_o(rx_coding_cfg_o),
  .clock_data_recovery_bypass_o(clock_data_recovery_bypass_o),
  .rx_data_pos_out_o(rx_data_pos_out_o), .rx_data_neg_out_o(rx_data_neg_out_o),
  .rx_recovered_clock_o(rx_recovered_clock_o));

/* File: verification/eli_cable_model.sv */
`timescale 1ns/1ps
module eli_cable_model (
  input  wire clk_sys_i,
  input  wire mclk_run_i,
  input  wire tclk_run_i,
  output reg  mclk_o = 1'b0,
  output reg  tclk_o = 1'b0,
  output wire slicer_pos_o,
  output wire slicer_neg_o,
  output wire cdr_pos_o,
  output wire cdr_neg_o,
  output wire cdr_clk_o
);
  reg [15:0] lfsr_reg = 16'hace1;
  // stopped clocks stand still, so loss detection sees no edge at all
  always #61 if (mclk_run_i) mclk_o = ~mclk_o;
  always #244 if (tclk_run_i) tclk_o = ~tclk_o;
  always @(negedge clk_sys_i) begin
    lfsr_reg <= {lfsr_reg[14:0], lfsr_reg[15] ^ lfsr_reg[13] ^ lfsr_reg[12] ^ lfsr_reg[10]};
  end
  // a mark sits on one rail only, as on a bipolar line
  assign slicer_pos_o = lfsr_reg[0] & lfsr_reg[1];
  assign slicer_neg_o = lfsr_reg[0] & ~lfsr_reg[1];
  assign cdr_pos_o = lfsr_reg[2] & lfsr_reg[3];
  assign cdr_neg_o = lfsr_reg[2] & ~lfsr_reg[3];
  assign cdr_clk_o = lfsr_reg[4];
endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ps
`include "eli_defs.vh"
module tb;
  reg        clk = 1'b0;
  reg        rst_n = 1'b0;
  reg        sw_rst = 1'b0;
  reg        cs = 1'b0;
  reg        we = 1'b0;
  reg        re = 1'b0;
  reg  [5:0] addr = 6'h00;
  reg  [7:0] wdata = 8'h00;
  reg        hw_mode = 1'b0;
  reg        force_pin = 1'b0;
  reg        imp_pin = 1'b0;
  reg        bridge_pin = 1'b0;
  reg  [1:0] seq_pins = 2'h0;
  reg  [1:0] coding_pins = 2'h0;
  reg  [3:0] tmpl_pins = 4'h0;
  reg        loopback = 1'b0;
  reg        pattern = 1'b0;
  reg  [5:0] waddr = 6'h00;
  reg        mclk_run = 1'b1;
  reg        tclk_run = 1'b1;
  reg  [5:0] ofs [0:7] = '{6'h02, 6'h04, 6'h05, 6'h06, 6'h09, 6'h0a, 6'h0b, 6'h3f};
  wire       mclk, tclk, s_pos, s_neg, c_pos, c_neg, c_clk, oe, pdn, eq, sens, bypass;
  wire [7:0] rdata, pct;
  wire [6:0] sample;
  wire [2:0] tx_term, rx_term;
  wire [4:0] los;
  wire [1:0] mg, decision_level_sel, coding;
  integer    errors = 0;
  integer    tests_run = 0;
  integer    i;
  reg  [7:0] v, r, q;
  always #4 clk = ~clk;
  eli_line_ctrl #(.TCLK_LOSS_CYC(40)) DUT (
    .clk_sys_i(clk), .resetn_i(rst_n), .sw_reset_i(sw_rst), .reg_cs_i(cs), .reg_wr_i(we),
    .reg_rd_i(re), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .hw_mode_pin_i(hw_mode), .tx_force_hiz_pin_i(force_pin), .hw_impedance_sel_pin_i(imp_pin),
    .hw_bridge_gain_pin_i(bridge_pin), .hw_tx_sequence_pins_i(seq_pins),
    .hw_path_coding_pins_i(coding_pins), .hw_wave_template_pins_i(tmpl_pins),
    .mclk_pin_i(mclk), .tx_line_clock_i(tclk), .remote_loopback_i(loopback),
    .tx_pattern_mclk_i(pattern), .shaper_ui_i(waddr[5:4]), .shaper_phase_i(waddr[3:0]),
    .slicer_pos_i(s_pos), .slicer_neg_i(s_neg), .cdr_pos_i(c_pos), .cdr_neg_i(c_neg),
    .cdr_clk_i(c_clk), .tx_line_oe_o(oe), .tx_power_down_o(pdn), .tx_term_code_o(tx_term),
    .rx_term_code_o(rx_term), .wave_sample_value_o(sample), .amplitude_pct_o(pct),
    .monitor_gain_field_o(mg), .adaptive_gain_enable_o(eq), .rx_sens_high_o(sens),
    .los_level_o(los), .decision_level_sel_o(decision_level_sel), .rx_coding_cfg_o(coding),
    .clock_data_recovery_bypass_o(bypass), .rx_data_pos_out_o(), .rx_data_neg_out_o(),
    .rx_recovered_clock_o());
  eli_cable_model u_cable (
    .clk_sys_i(clk), .mclk_run_i(mclk_run), .tclk_run_i(tclk_run), .mclk_o(mclk),
    .tclk_o(tclk), .slicer_pos_o(s_pos), .slicer_neg_o(s_neg), .cdr_pos_o(c_pos),
    .cdr_neg_o(c_neg), .cdr_clk_o(c_clk));
  task chk(input string name, input [31:0] seen, input [31:0] exp);
    begin
      tests_run = tests_run + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("unexpected %0s: expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task tick(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // derived outputs land one edge after the write is taken
  task wr(input [5:0] a, input [7:0] d);
    begin
      cs = 1'b1;
      we = 1'b1;
      addr = a;
      wdata = d;
      tick(1);
      cs = 1'b0;
      we = 1'b0;
      tick(3);
    end
  endtask
  task rd(input [5:0] a, output [7:0] d);
    begin
      cs = 1'b1;
      re = 1'b1;
      addr = a;
      tick(1);
      cs = 1'b0;
      re = 1'b0;
      tick(1);
      d = rdata;
    end
  endtask
  task wait_oe(input exp, input integer lim);
    integer n;
    begin
      n = 0;
      while (oe !== exp && n < lim) begin
        tick(1);
        n = n + 1;
      end
      chk("tx_line_oe", oe, exp);
    end
  endtask
  function [6:0] exp_wave(input is120, input [5:0] k);
    begin
      if (k == 6'h03) exp_wave = is120 ? 7'h0f : 7'h0c;
      else if (k >= 6'h04 && k <= 6'h0b) exp_wave = is120 ? 7'h3c : 7'h30;
      else exp_wave = 7'h00;
    end
  endfunction
  task end_of_test;
    begin
      $display("comparisons %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    errors = errors + 1;
    end_of_test;
  end
  initial begin
    v = $urandom(32'h6569);
    tick(12);
    rst_n = 1'b1;
    tick(1);
    chk("oe after reset", oe, 1'b0);
    chk("pct after reset", pct, 8'h64);
    for (i = 0; i < 8; i = i + 1) begin
      rd(ofs[i], r);
      chk("reset value", r, (ofs[i] == 6'h06) ? 8'h21 : 8'h00);
    end
    wr(6'h3f, 8'hff);
    rd(6'h3f, r);
    chk("unmapped", r, 8'h00);
    $display("test reset done");
    for (i = 0; i < 12; i = i + 1) begin
      v = $urandom;
      v[2:0] = i[2:0];
      wr(`ELI_OFS_LINE_IMP, v);
      chk("tx_term", tx_term, v[2] ? 3'h4 : {1'b0, v[1:0]});
      chk("rx_term", rx_term, v[5] ? 3'h4 : {1'b0, v[4:3]});
      rd(`ELI_OFS_LINE_IMP, r);
      chk("line_impedance_cfg", r & 8'h3f, v & 8'h3f);
    end
    $display("test termination done");
    for (i = 0; i < 4; i = i + 1) begin
      v = $urandom;
      wr(`ELI_OFS_RX_CFG2, {4'h0, i[1:0], ~i[1:0]});
      chk("monitor_gain", mg, i[1:0]);
      chk("decision_level", decision_level_sel, {~i[1:0]});
      wr(`ELI_OFS_RX_CFG0, {6'h00, i[1:0]});
      chk("rx_coding", coding, i[1:0]);
      chk("bypass", bypass, i[1:0] == 2'h3);
      tick(20);
      wr(`ELI_OFS_RX_CFG1, {i[0], 2'h0, v[4:0]});
      chk("eq", eq, i[0]);
      chk("sens", sens, i[0]);
      chk("los", los, v[4:0]);
    end
    $display("test receive done");
    for (i = 0; i < 128; i = i + 1) begin
      if (i[5:0] == 6'h00) wr(`ELI_OFS_TX_CFG1, {7'h00, i[6]});
      waddr = i[5:0];
      tick(3);
      chk("wave_sample", sample, exp_wave(i[6], i[5:0]));
      chk("preset pct", pct, 8'h64);
    end
    $display("test presets done");
    wr(`ELI_OFS_TX_CFG1, 8'h0c);
    for (i = 0; i < 8; i = i + 1) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'h3f : (i == 2) ? 8'h21 : $urandom;
      wr(`ELI_OFS_TX_CFG2, {2'h0, v[5:0]});
      chk("amplitude", pct, v[5:0] * 8'h03 + 8'h01);
      r = $urandom;
      wr(`ELI_OFS_WAVE_DATA, {1'b0, r[6:0]});
      wr(`ELI_OFS_WAVE_CTRL, {2'h2, v[5:0]});
      wr(`ELI_OFS_WAVE_CTRL, {2'h3, v[5:0]});
      rd(`ELI_OFS_WAVE_DATA, q);
      chk("ram readback", q & 8'h7f, {1'b0, r[6:0]});
      waddr = v[5:0];
      tick(3);
      chk("user sample", sample, r[6:0]);
    end
    $display("test user wave done");
    wait_oe(1'b1, 300);
    force_pin = 1'b1;
    wait_oe(1'b0, 8);
    force_pin = 1'b0;
    wait_oe(1'b1, 8);
    wr(`ELI_OFS_TX_CFG1, 8'h1c);
    chk("force bit", oe, 1'b0);
    wr(`ELI_OFS_TX_CFG1, 8'h0c);
    wr(`ELI_OFS_TX_CFG0, 8'h10);
    chk("pdn", pdn, 1'b1);
    chk("pdn oe", oe, 1'b0);
    wr(`ELI_OFS_TX_CFG0, 8'h00);
    wait_oe(1'b1, 8);
    sw_rst = 1'b1;
    tick(3);
    chk("sw reset oe", oe, 1'b0);
    sw_rst = 1'b0;
    wait_oe(1'b1, 300);
    mclk_run = 1'b0;
    wait_oe(1'b0, 300);
    mclk_run = 1'b1;
    wait_oe(1'b1, 300);
    tclk_run = 1'b0;
    wait_oe(1'b0, 300);
    loopback = 1'b1;
    wait_oe(1'b1, 10);
    loopback = 1'b0;
    pattern = 1'b1;
    wait_oe(1'b1, 10);
    pattern = 1'b0;
    wait_oe(1'b0, 10);
    tclk_run = 1'b1;
    wait_oe(1'b1, 300);
    $display("test hiz done");
    hw_mode = 1'b1;
    for (i = 0; i < 8; i = i + 1) begin
      v = $urandom;
      imp_pin = i[0];
      bridge_pin = i[1];
      coding_pins = i[2:1];
      seq_pins = i[2] ? 2'h3 : {1'b0, v[4]};
      tmpl_pins = (i < 2) ? 4'h0 : v[3:0];
      tick(6);
      v[2:0] = imp_pin ? 3'h4 : {2'h0, tmpl_pins != 4'h0};
      chk("hw tx_term", tx_term, v[2:0]);
      chk("hw rx_term", rx_term, v[2:0]);
      chk("hw mg", mg, bridge_pin ? 2'h2 : 2'h0);
      chk("hw pdn", pdn, seq_pins == 2'h3);
      chk("hw coding", coding, coding_pins);
      chk("hw eq", eq, 1'b0);
      chk("hw sens", sens, 1'b0);
      chk("hw los", los, 5'h00);
      // strapped template picks preset table or the ram word written last at waddr
      q = (tmpl_pins[3:2] == 2'h3) ? {1'b0, r[6:0]} : {1'b0, exp_wave(tmpl_pins != 4'h0, waddr)};
      chk("hw sample", sample, q[6:0]);
    end
    hw_mode = 1'b0;
    $display("test pin mode done");
    end_of_test;
  end
endmodule
